// File: common/gpfs_pkg.sv
// Purpose: Shared constants, types and helpers for the pin function select block.
// Assumes: Twenty pins, three-bit function codes, six alternate functions per pin.
// Notes: Register addresses are full byte addresses on the APB bus.
package gpfs_pkg;
  localparam int NPINS = 20; // Pins covered by the two select registers
  localparam int NALT = 6; // Alternate functions per pin
  localparam int CODEW = 3; // Width of one function code
  localparam int PER_REG = 10; // Codes held by one register
  localparam int ALTW = NPINS * NALT; // Flat width of per-pin alternate buses
  localparam int CODESW = NPINS * CODEW; // Flat width of all codes
  localparam int FIELDS_MSB = 29; // Top bit of the used fields
  localparam int SEL1_HI_LSB = 27; // Low bit of the last field in a register
  localparam logic [31:0] ADDR_SEL0 = 32'h7e200000; // First select register
  localparam logic [31:0] ADDR_SEL1 = 32'h7e200004; // Second select register
  localparam logic [31:0] SEL_RESET = 32'h00000000; // Reset value, all inputs
  localparam logic [31:0] SEL_MASK = 32'h3fffffff; // Bits 31..30 read as zero
  localparam logic [31:0] RD_ZERO = 32'h00000000; // Read data when unmapped
  // Alternate lines actually fed by a peripheral; a zero ties that line low
  localparam logic [ALTW-1:0] ALT_USED = {ALTW{1'b1}};
  typedef logic [CODEW-1:0] gpfs_code_t;
  localparam gpfs_code_t CODE_IN = 3'h0; // Plain input
  localparam gpfs_code_t CODE_OUT = 3'h1; // Plain output
  localparam gpfs_code_t CODE_ALT0 = 3'h4;
  localparam gpfs_code_t CODE_ALT1 = 3'h5;
  localparam gpfs_code_t CODE_ALT2 = 3'h6;
  localparam gpfs_code_t CODE_ALT3 = 3'h7;
  localparam gpfs_code_t CODE_ALT4 = 3'h3;
  localparam gpfs_code_t CODE_ALT5 = 3'h2;
  localparam logic [2:0] ALT_NONE = 3'h7; // No alternate selected
  // Bus phase states, Gray along idle to answer
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_ANSWER = 2'h1
  } gpfs_state_t;

  // Maps a function code to its alternate number, or ALT_NONE
  function automatic logic [2:0] gpfs_alt_of(input gpfs_code_t code);
    logic [2:0] alt;
    alt = ALT_NONE;
    case (code)
      CODE_ALT0: alt = 3'h0;
      CODE_ALT1: alt = 3'h1;
      CODE_ALT2: alt = 3'h2;
      CODE_ALT3: alt = 3'h3;
      CODE_ALT4: alt = 3'h4;
      CODE_ALT5: alt = 3'h5;
      default: alt = ALT_NONE;
    endcase
    return alt;
  endfunction : gpfs_alt_of

  // Picks one bit of a pin's alternate group
  function automatic logic gpfs_pick(input logic [NALT-1:0] vec, input logic [2:0] alt);
    logic bitVal;
    bitVal = 1'b0;
    if (alt != ALT_NONE) begin
      bitVal = vec[alt];
    end
    return bitVal;
  endfunction : gpfs_pick
endpackage : gpfs_pkg

// File: common/gpfs_sel_if.sv
// Purpose: Carries codes and pin-side signals between register side and multiplexer.
// Assumes: Both ends run on ref_clk; the multiplexer is purely combinational.
// Notes: Flat vectors, pin p owns bits [p*NALT +: NALT] of alternate buses.
`timescale 1ns/10ps
interface gpfs_sel_if;
  import gpfs_pkg::*;
  logic [CODESW-1:0] codes; // All function codes, pin 0 lowest
  logic [NPINS-1:0] gpioOut; // General-purpose output values
  logic [ALTW-1:0] altOut; // Peripheral output values
  logic [ALTW-1:0] altOe; // Peripheral output enables
  logic [NPINS-1:0] pinLevel; // Synchronised pad levels
  logic [NPINS-1:0] muxOut; // Selected pad drive value
  logic [NPINS-1:0] muxOe; // Selected pad output enable
  logic [ALTW-1:0] altIn; // Pad level steered to the chosen peripheral
  modport ctrl (
    output codes, gpioOut, altOut, altOe, pinLevel,
    input muxOut, muxOe, altIn
  );
  modport mux (
    input codes, gpioOut, altOut, altOe, pinLevel,
    output muxOut, muxOe, altIn
  );
endinterface : gpfs_sel_if

// File: verilog/gpfs_pin_mux.sv
// Purpose: Per-pin function multiplexer steered by the three-bit codes.
// Assumes: Inputs are already in the ref_clk domain.
// Notes: Combinational; the top module registers every result.
`timescale 1ns/10ps
module gpfs_pin_mux (
  gpfs_sel_if.mux sel
);
  import gpfs_pkg::*;

  // One slice per pin
  for (genvar p = 0; p < NPINS; p++) begin : g_pin
    wire gpfs_code_t code = sel.codes[p*CODEW +: CODEW]; // This pin's code
    wire [2:0] alt = gpfs_alt_of(code); // R4 R5
    wire isOut = (code == CODE_OUT); // Plain output
    wire [NALT-1:0] used = ALT_USED[p*NALT +: NALT]; // Fed alternates
    wire [NALT-1:0] aOut = sel.altOut[p*NALT +: NALT] & used; // R6
    wire [NALT-1:0] aOe = sel.altOe[p*NALT +: NALT] | ~used; // R6
    // Drive value: GPIO output, an alternate, or nothing for input
    assign sel.muxOut[p] = isOut ? sel.gpioOut[p] : gpfs_pick(aOut, alt);
    // Driver on for output; alternate decides its own; input releases
    assign sel.muxOe[p] = isOut ? 1'b1 : gpfs_pick(aOe, alt);
    // Pad level reaches only the selected peripheral
    for (genvar a = 0; a < NALT; a++) begin : g_alt
      assign sel.altIn[p*NALT + a] = (alt == 3'(a)) & sel.pinLevel[p];
    end
  end
endmodule : gpfs_pin_mux

// File: verilog/gpfs_top.sv
// Purpose: Pin function select for pins 0 to 19, APB slave with two select registers.
// Assumes: Synchronous active-high reset; clkEn low freezes all state.
// Notes: No wait state on any APB access; pad inputs pass three flip-flops.
`timescale 1ns/10ps

// Behaviour
// R1: One three-bit code alone sets each pin
// R2: Code 000 makes pin input, driver released
// R3: Code 001 drives pin from GPIO output
// R4: Codes 100..111 select alternates 0..3
// R5: Code 011 alternate 4, 010 alternate 5
// R6: Unused alternate lines tied low, drive 0
// R7: Reset clears all codes to input
// R8: First register holds pins 0..9, three bits each
// R9: Second register holds pins 10..19 likewise
// R10: Bits 31..30 read zero, ignore writes
// R11: Software uses full 32-bit accesses only
// R12: Registers decoded at 0x7E200000 and 0x7E200004
module gpfs_top (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic [31:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [gpfs_pkg::NPINS-1:0] gpioOut,
  input wire logic [gpfs_pkg::ALTW-1:0] altOut,
  input wire logic [gpfs_pkg::ALTW-1:0] altOe,
  input wire logic [gpfs_pkg::NPINS-1:0] pinIn,
  output logic [gpfs_pkg::NPINS-1:0] pinOut,
  output logic [gpfs_pkg::NPINS-1:0] pinOe,
  output logic [gpfs_pkg::NPINS-1:0] gpioIn,
  output logic [gpfs_pkg::ALTW-1:0] altIn
);
  import gpfs_pkg::*;

  // Select registers
  logic [31:0] sel0_q; // Pins 0..9
  logic [31:0] sel0_d;
  logic [31:0] sel1_q; // Pins 10..19
  logic [31:0] sel1_d;
  // Bus answer registers
  gpfs_state_t state_q; // Bus phase
  gpfs_state_t state_d;
  logic [31:0] prdata_q; // Read data held through access phase
  logic [31:0] prdata_d;
  logic pready_q; // Access phase ready
  logic pslverr_q; // Unmapped address flag
  logic pslverr_d;
  // Pad input synchroniser
  logic [NPINS-1:0] meta_q; // First stage, read only by second
  logic [NPINS-1:0] sync_q; // Second stage, safe to use
  // Registered pin-side outputs
  logic [NPINS-1:0] pinOut_q;
  logic [NPINS-1:0] pinOe_q;
  logic [NPINS-1:0] gpioIn_q;
  logic [ALTW-1:0] altIn_q;

  // Carrier to the multiplexer
  gpfs_sel_if selIf ();

  // Address decode
  wire hitSel0 = (paddr == ADDR_SEL0); // R12
  wire hitSel1 = (paddr == ADDR_SEL1); // R12
  wire hitAny = hitSel0 | hitSel1;
  wire setupPh = psel & ~penable; // Setup cycle
  wire doneEdge = psel & penable & pready_q; // Transfer completes here
  wire wrDone = doneEdge & pwrite; // Write takes effect
  wire [31:0] wrVal = pwdata & SEL_MASK; // R10

  // Read data selection by address
  logic [31:0] rdSel;
  always_comb begin
    if (hitSel0) begin
      rdSel = sel0_q & SEL_MASK; // R10
    end else if (hitSel1) begin
      rdSel = sel1_q & SEL_MASK; // R10
    end else begin
      rdSel = RD_ZERO;
    end
  end

  // Next register values; only a completed write changes them
  assign sel0_d = (wrDone && hitSel0) ? wrVal : sel0_q; // R8
  assign sel1_d = (wrDone && hitSel1) ? wrVal : sel1_q; // R9

  // Answer is prepared in setup, shown in the access phase
  assign state_d = (state_q == ST_IDLE && setupPh) ? ST_ANSWER : ST_IDLE;
  assign prdata_d = (setupPh && !pwrite) ? rdSel : RD_ZERO;
  assign pslverr_d = setupPh & ~hitAny;

  // Code register update
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel0_q <= SEL_RESET; // R7
      sel1_q <= SEL_RESET; // R7
    end else if (clkEn) begin
      sel0_q <= sel0_d;
      sel1_q <= sel1_d;
    end
  end

  // Bus answer update
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      pready_q <= 1'b0;
      prdata_q <= RD_ZERO;
      pslverr_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;
      pready_q <= (state_d == ST_ANSWER);
      prdata_q <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Pad synchroniser
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else if (clkEn) begin
      meta_q <= pinIn;
      sync_q <= meta_q;
    end
  end

  // Carrier drive
  assign selIf.codes = {sel1_q[FIELDS_MSB:0], sel0_q[FIELDS_MSB:0]}; // R1
  assign selIf.gpioOut = gpioOut;
  assign selIf.altOut = altOut;
  assign selIf.altOe = altOe;
  assign selIf.pinLevel = sync_q;

  // Multiplexer
  gpfs_pin_mux u_mux (
    .sel(selIf)
  );

  // Pin-side registers; reset leaves every driver released
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pinOut_q <= '0;
      pinOe_q <= '0; // R2
      gpioIn_q <= '0;
      altIn_q <= '0;
    end else if (clkEn) begin
      pinOut_q <= selIf.muxOut; // R3
      pinOe_q <= selIf.muxOe; // R2
      gpioIn_q <= sync_q;
      altIn_q <= selIf.altIn; // R4
    end
  end

  // Ports from flip-flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pinOut = pinOut_q;
  assign pinOe = pinOe_q;
  assign gpioIn = gpioIn_q;
  assign altIn = altIn_q;

  // Checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // Write completion to each register
  sequence s_wr_sel0;
    clkEn && psel && penable && pready && pwrite && paddr == ADDR_SEL0;
  endsequence
  sequence s_wr_sel1;
    clkEn && psel && penable && pready && pwrite && paddr == ADDR_SEL1;
  endsequence
  // Setup of a read from the first register
  sequence s_rd_setup0;
    clkEn && psel && !penable && !pwrite && paddr == ADDR_SEL0 && !pready;
  endsequence

  // Input code releases the driver of pin 0
  property p_in_release;
    (clkEn && sel0_q[2:0] == CODE_IN) |=> !pinOe[0];
  endproperty
  a_in_release: assert property (p_in_release) else $error("input code left driver on"); // R2

  // Output code on pin 19 drives the GPIO value
  property p_out_drive;
    (clkEn && sel1_q[FIELDS_MSB:SEL1_HI_LSB] == CODE_OUT)
      |=> pinOe[NPINS-1] && pinOut[NPINS-1] == $past(gpioOut[NPINS-1]);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("output code not driving GPIO"); // R3

  // Alternate 0 on pin 9 routes its peripheral line
  property p_alt0;
    (clkEn && sel0_q[FIELDS_MSB:SEL1_HI_LSB] == CODE_ALT0)
      |=> pinOut[PER_REG-1] == $past(altOut[(PER_REG-1)*NALT] & ALT_USED[(PER_REG-1)*NALT]);
  endproperty
  a_alt0: assert property (p_alt0) else $error("alternate 0 not routed"); // R4

  // Alternate 4 on pin 0 routes line 4 and its enable
  property p_alt4;
    (clkEn && sel0_q[2:0] == CODE_ALT4)
      |=> pinOut[0] == $past(altOut[4] & ALT_USED[4]) && pinOe[0] == $past(altOe[4] | ~ALT_USED[4]);
  endproperty
  a_alt4: assert property (p_alt4) else $error("alternate 4 not routed"); // R5

  // Alternate 5 on pin 0 routes line 5; an unused line drives a low level
  property p_tie_low;
    (clkEn && sel0_q[2:0] == CODE_ALT5)
      |=> pinOut[0] == $past(altOut[5] & ALT_USED[5]) && pinOe[0] == $past(altOe[5] | ~ALT_USED[5]);
  endproperty
  a_tie_low: assert property (p_tie_low) else $error("unused alternate not low"); // R6

  // Reset returns every code to input and releases pin drivers
  property p_reset_clear;
    disable iff (1'b0) reset |=> sel0_q == SEL_RESET && sel1_q == SEL_RESET && pinOe == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset did not clear codes"); // R7

  // Write to the second register lands with top bits dropped
  property p_wr_sel1;
    s_wr_sel1 |=> sel1_q == ($past(pwdata) & SEL_MASK) && sel1_q[31:30] == 2'h0;
  endproperty
  a_wr_sel1: assert property (p_wr_sel1) else $error("second register write wrong"); // R10

  // Read of the first register answers one cycle after setup
  property p_rd_sel0;
    s_rd_setup0 |=> pready && !pslverr && prdata == ($past(sel0_q) & SEL_MASK);
  endproperty
  a_rd_sel0: assert property (p_rd_sel0) else $error("first register read wrong"); // R12

  // Codes change only through a completed write
  property p_code_hold;
    (clkEn && !(psel && penable && pready && pwrite)) |=> $stable(sel0_q) && $stable(sel1_q);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("code changed without write"); // R1

  // A write to the first register still holds two cycles after it completes
  property p_wr_sel0;
    s_wr_sel0 ##1 (!(psel && penable && pwrite))[*2] |-> sel0_q == ($past(pwdata, 2) & SEL_MASK);
  endproperty
  a_wr_sel0: assert property (p_wr_sel0) else $error("first register write lost"); // R8
endmodule : gpfs_top

// File: tb/gpfs_pad_model.sv
// Purpose: Pad model for pins 0 to 19, far side of the multiplexer.
// Assumes: Pads are ideal; no drive strength or contention.
// Notes: A released pad shows the external level set by the bench.
`timescale 1ns/10ps
module gpfs_pad_model
  import gpfs_pkg::*;
(
  input wire logic [NPINS-1:0] pinOut, // Drive value from the block
  input wire logic [NPINS-1:0] pinOe, // High while the block drives
  input wire logic [NPINS-1:0] extLevel, // Level seen when released
  output logic [NPINS-1:0] pinIn // Pad level back to the block
);
  // Driven pads echo the drive value, released pads the outside level
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule : gpfs_pad_model

// File: tb/tb_gpio_pin_function_select.sv
// Purpose: Self-checking bench for the pin function select block.
// Assumes: APB answers are checked in order by a monitor process.
// Notes: Random codes, pad levels and peripheral values from seed 20.
`timescale 1ns/10ps
module tb_gpio_pin_function_select;
  import gpfs_pkg::*;
  logic ref_clk, reset, clkEn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata, wv0, wv1;
  logic [NPINS-1:0] gpioOut, pinIn, pinOut, pinOe, gpioIn, extLevel, eOe, eOut;
  logic [ALTW-1:0] altOut, altOe, altIn, eAlt;
  logic [32:0] expQ[$]; // Expected {pslverr, prdata} per answer
  logic [2:0] code;
  int fails, cmp_count, seed, a;
  int altOf[8] = '{7, 7, 5, 4, 0, 1, 2, 3}; // Code to alternate, 7 none

  gpfs_top uut (.ref_clk(ref_clk), .reset(reset), .clkEn(clkEn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpioOut(gpioOut),
    .altOut(altOut), .altOe(altOe), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .gpioIn(gpioIn), .altIn(altIn));
  gpfs_pad_model pads (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn));

  // Clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compares and counts
  task check(input logic [ALTW-1:0] seen, input logic [ALTW-1:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task final_report;
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  // One full-word APB transfer; e is the expected answer
  task apb(input logic w, input logic [31:0] ad, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    expQ.push_back(e);
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      fails++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Monitor takes the oldest note whenever an answer completes
  always @(posedge ref_clk) begin
    if (psel && penable && pready === 1'b1) begin
      check({pslverr, prdata}, expQ.pop_front());
    end
  end

  // Watchdog
  initial begin
    #100000;
    fails++;
    final_report();
  end

  // Main sequence
  initial begin
    seed = 20;
    fails = 0;
    cmp_count = 0;
    reset = 1'b1;
    clkEn = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    gpioOut = '0;
    altOut = '0;
    altOe = '0;
    extLevel = '0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    check(pinOe, '0);
    apb(1'b0, ADDR_SEL0, 32'h0, 33'h0);
    apb(1'b0, ADDR_SEL1, 32'h0, 33'h0);
    apb(1'b1, ADDR_SEL1 + 32'h4, 32'hffffffff, {1'b1, 32'h0});
    apb(1'b0, ADDR_SEL1 + 32'h4, 32'h0, {1'b1, 32'h0});
    apb(1'b0, ADDR_SEL1, 32'h0, 33'h0);
    for (int r = 0; r < 8; r++) begin
      wv0 = $random(seed);
      wv1 = $random(seed);
      wv0[2:0] = r[2:0];
      wv1[29:27] = 3'(7 - r);
      apb(1'b1, ADDR_SEL0, wv0, 33'h0);
      apb(1'b1, ADDR_SEL1, wv1, 33'h0);
      apb(1'b0, ADDR_SEL0, 32'h0, {3'h0, wv0[29:0]});
      apb(1'b0, ADDR_SEL1, 32'h0, {3'h0, wv1[29:0]});
      @(posedge ref_clk);
      gpioOut <= NPINS'($random(seed));
      altOut <= ALTW'({$random(seed), $random(seed), $random(seed), $random(seed)});
      altOe <= ALTW'({$random(seed), $random(seed), $random(seed), $random(seed)});
      extLevel <= NPINS'($random(seed));
      repeat (6) @(posedge ref_clk);
      #1;
      eOe = '0;
      eOut = '0;
      eAlt = '0;
      for (int p = 0; p < NPINS; p++) begin
        code = (p < 10) ? wv0[3*p +: 3] : wv1[3*(p-10) +: 3];
        a = altOf[code];
        if (code == CODE_OUT) begin
          eOe[p] = 1'b1;
          eOut[p] = gpioOut[p];
        end else if (a < NALT) begin
          eOe[p] = altOe[p*NALT+a] | ~ALT_USED[p*NALT+a];
          eOut[p] = altOut[p*NALT+a] & ALT_USED[p*NALT+a];
          eAlt[p*NALT+a] = pinIn[p];
        end
      end
      check(pinOe, eOe);
      check(pinOut, eOut);
      check(altIn, eAlt);
      check(gpioIn, pinIn);
    end
    // Clock enable low freezes the pin outputs while inputs change
    @(posedge ref_clk);
    clkEn <= 1'b0;
    eOe = pinOe;
    eOut = pinOut;
    gpioOut <= ~gpioOut;
    altOut <= ~altOut;
    altOe <= ~altOe;
    repeat (3) @(posedge ref_clk);
    #1;
    check(pinOe, eOe);
    check(pinOut, eOut);
    @(posedge ref_clk);
    clkEn <= 1'b1;
    // Reset in mid-run returns every code to input
    @(posedge ref_clk);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    check(pinOe, '0);
    apb(1'b0, ADDR_SEL0, 32'h0, 33'h0);
    apb(1'b0, ADDR_SEL1, 32'h0, 33'h0);
    repeat (2) @(posedge ref_clk);
    final_report();
  end
endmodule : tb_gpio_pin_function_select
